// File: hw/nsid_consts.vh
/*
 * Constants for the NAND status / ID / reset / parameter page host controller.
 * Assumes a 40 MHz system clock; cycle counts are derived from the period.
 */
`ifndef NSID_CONSTS_VH
`define NSID_CONSTS_VH

`define NSID_CLK_NS        25
// Least times round up to whole cycles
`define NSID_CYC_MIN(ns)   ((((ns) + `NSID_CLK_NS - 1) / `NSID_CLK_NS) < 1 ? 1 : \
                            (((ns) + `NSID_CLK_NS - 1) / `NSID_CLK_NS))
`define NSID_T_WP_NS       25
`define NSID_T_WH_NS       25
`define NSID_T_RP_NS       100
`define NSID_T_REH_NS      25
`define NSID_T_WB_NS       100
`define NSID_WP_CYC        `NSID_CYC_MIN(`NSID_T_WP_NS)
`define NSID_WH_CYC        `NSID_CYC_MIN(`NSID_T_WH_NS)
`define NSID_RP_CYC        `NSID_CYC_MIN(`NSID_T_RP_NS)
`define NSID_REH_CYC       `NSID_CYC_MIN(`NSID_T_REH_NS)
`define NSID_WB_CYC        `NSID_CYC_MIN(`NSID_T_WB_NS)

// Device command codes and the ID address bytes
`define NSID_CMD_STATUS    8'h70
`define NSID_CMD_READ_ID   8'h90
`define NSID_CMD_RESET     8'hFF
`define NSID_CMD_PARAM     8'hEC
`define NSID_CMD_COL       8'h05
`define NSID_CMD_COL_CONF  8'hE0
`define NSID_CMD_RESUME    8'h00
`define NSID_ADDR_ID       8'h00
`define NSID_ADDR_SIG      8'h20

// User operations
`define NSID_OP_STATUS     3'h0
`define NSID_OP_ID         3'h1
`define NSID_OP_SIG        3'h2
`define NSID_OP_RESET      3'h3
`define NSID_OP_PARAM      3'h4
`define NSID_OP_COL        3'h5
`define NSID_OP_RESUME     3'h6

`define NSID_ID_BYTES      9'h005
`define NSID_SIG_BYTES     9'h004
`define NSID_STATUS_RESET  8'hE0

// Status byte field positions
`define NSID_ST_FAIL       0
`define NSID_ST_FAIL_PREV  1
`define NSID_ST_ARRAY_IDLE 5
`define NSID_ST_CACHE_RDY  6
`define NSID_ST_WP_OFF     7

// Pin cycle kinds
`define NSID_KIND_CMD      2'h0
`define NSID_KIND_ADDR     2'h1
`define NSID_KIND_READ     2'h2

`endif

// File: hw/nsid_cycle.v
/*
 * One bus cycle on the NAND pins: command latch, address latch or data read.
 * Assumes the caller holds chip enable low and pulses i_go only while o_idle.
 */
`timescale 1ns/10ps
`include "nsid_consts.vh"

module nsid_cycle (
	input  wire       i_clk_sys,
	input  wire       i_rst_b,
	input  wire       i_go,
	input  wire [1:0] i_kind,
	input  wire [7:0] i_byte,
	input  wire [7:0] i_dq_in,
	output reg        o_idle,
	output reg        o_done,
	output reg  [7:0] o_rdata,
	output reg        o_cle,
	output reg        o_ale,
	output reg        o_we_n,
	output reg        o_re_n,
	output reg  [7:0] o_dq_out,
	output reg        o_dq_oe_n
);

	localparam [1:0] E_IDLE = 2'h0;
	localparam [1:0] E_LOW  = 2'h1;
	localparam [1:0] E_HIGH = 2'h2;

	reg [1:0] st_q;
	reg [3:0] cnt_q;
	reg       rd_q;
	reg [7:0] dq_m_q;
	reg [7:0] dq_s_q;

	// Counts arrive as integers; only the low bits fit the counter
	function [3:0] cnt_ld;
		input integer n;
		cnt_ld = n[3:0];
	endfunction

	// Data pins are asynchronous; strobe low time covers the two-stage delay
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dq_m_q <= 8'h00;
			dq_s_q <= 8'h00;
		end else begin
			dq_m_q <= i_dq_in;
			dq_s_q <= dq_m_q;
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q      <= E_IDLE;
			cnt_q     <= 4'h0;
			rd_q      <= 1'b0;
			o_idle    <= 1'b1;
			o_done    <= 1'b0;
			o_rdata   <= 8'h00;
			o_cle     <= 1'b0;
			o_ale     <= 1'b0;
			o_we_n    <= 1'b1;
			o_re_n    <= 1'b1;
			o_dq_out  <= 8'h00;
			o_dq_oe_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			case (st_q)
			E_IDLE: begin
				if (i_go) begin
					st_q      <= E_LOW;
					o_idle    <= 1'b0;
					rd_q      <= (i_kind == `NSID_KIND_READ);
					o_cle     <= (i_kind == `NSID_KIND_CMD);
					o_ale     <= (i_kind == `NSID_KIND_ADDR);
					o_we_n    <= (i_kind == `NSID_KIND_READ);
					o_re_n    <= (i_kind != `NSID_KIND_READ);
					o_dq_out  <= i_byte;
					o_dq_oe_n <= (i_kind == `NSID_KIND_READ);
					cnt_q     <= (i_kind == `NSID_KIND_READ) ? cnt_ld(`NSID_RP_CYC - 1)
					                                         : cnt_ld(`NSID_WP_CYC - 1);
				end
			end
			E_LOW: begin
				if (cnt_q == 4'h0) begin
					st_q   <= E_HIGH;
					o_we_n <= 1'b1;
					o_re_n <= 1'b1;
					cnt_q  <= rd_q ? cnt_ld(`NSID_REH_CYC - 1) : cnt_ld(`NSID_WH_CYC - 1);
					if (rd_q)
						o_rdata <= dq_s_q;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			E_HIGH: begin
				if (cnt_q == 4'h0) begin
					st_q      <= E_IDLE;
					o_idle    <= 1'b1;
					o_done    <= 1'b1;
					o_cle     <= 1'b0;
					o_ale     <= 1'b0;
					o_dq_oe_n <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			default: begin
				st_q <= E_IDLE;
			end
			endcase
		end
	end

endmodule

// File: hw/nsid_host.v
/*
 * Host controller for status, identification, reset and parameter page reads
 * of a multiplexed-bus NAND device. Takes one operation at a time on a plain
 * user port and sequences the device pins through nsid_cycle.
 * Assumes ready_busy_n is open-drain with an external pull-up, asynchronous.
 */
// How it works
// - Identification is started by 90h then address 00h.
// - Signature uses 90h with address 20h and returns four ASCII bytes.
// - Bytes past the four signature bytes are undefined; never read them.
// - Change read column during parameter page read moves the output column.
// - After a status read inside a parameter page read, send 00h to resume.
// - Per-plane enhanced status is never used during a parameter page read.
// - After 70h each read cycle returns status until another command.
`timescale 1ns/10ps
`include "nsid_consts.vh"

module nsid_host #(
	parameter LEN_W = 9
) (
	input  wire             i_clk_sys,
	input  wire             i_rst_b,
	input  wire             i_req,
	input  wire [2:0]       i_op,
	input  wire [15:0]      i_col,
	input  wire [LEN_W-1:0] i_len,
	input  wire             i_ready_busy_n,
	input  wire [7:0]       i_dq_in,
	output reg              o_busy,
	output reg              o_done,
	output reg              o_refused,
	output reg              o_rd_valid,
	output reg  [7:0]       o_rd_data,
	output reg  [7:0]       o_status,
	output reg              o_st_fail,
	output reg              o_st_fail_prev,
	output reg              o_st_array_idle,
	output reg              o_st_cache_rdy,
	output reg              o_st_wp_off,
	output reg              o_ce_n,
	output reg              o_wp_n,
	output wire             o_cle,
	output wire             o_ale,
	output wire             o_we_n,
	output wire             o_re_n,
	output wire [7:0]       o_dq_out,
	output wire             o_dq_oe_n
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_CMD1 = 3'h1;
	localparam [2:0] S_ADDR = 3'h2;
	localparam [2:0] S_CMD2 = 3'h3;
	localparam [2:0] S_WB   = 3'h4;
	localparam [2:0] S_RDY  = 3'h5;
	localparam [2:0] S_READ = 3'h6;
	localparam [2:0] S_DONE = 3'h7;

	reg  [2:0]       st_q;
	reg  [2:0]       op_q;
	reg  [7:0]       cmd1_q;
	reg  [7:0]       addr0_q;
	reg  [7:0]       addr1_q;
	reg  [1:0]       naddr_q;
	reg  [1:0]       aidx_q;
	reg              cmd2_q;
	reg              wait_q;
	reg  [LEN_W-1:0] nread_q;
	reg  [3:0]       wb_q;
	reg              launch_q;
	reg              rst_pend_q;
	reg              rb_m_q;
	reg              rb_s_q;

	reg              eng_go;
	reg  [1:0]       eng_kind;
	reg  [7:0]       eng_byte;
	wire             eng_idle;
	wire             eng_done;
	wire [7:0]       eng_rdata;

	reg              accept;
	reg              refuse;

	// Counts arrive as integers; only the low bits fit the counter
	function [3:0] cnt_ld;
		input integer n;
		cnt_ld = n[3:0];
	endfunction

	nsid_cycle u_cycle (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_go      (eng_go),
		.i_kind    (eng_kind),
		.i_byte    (eng_byte),
		.i_dq_in   (i_dq_in),
		.o_idle    (eng_idle),
		.o_done    (eng_done),
		.o_rdata   (eng_rdata),
		.o_cle     (o_cle),
		.o_ale     (o_ale),
		.o_we_n    (o_we_n),
		.o_re_n    (o_re_n),
		.o_dq_out  (o_dq_out),
		.o_dq_oe_n (o_dq_oe_n)
	);

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rb_m_q <= 1'b0;
			rb_s_q <= 1'b0;
		end else begin
			rb_m_q <= i_ready_busy_n;
			rb_s_q <= rb_m_q;
		end
	end

	// Status polling is allowed while busy; reset may abort a busy device
	always @* begin
		refuse = 1'b0;
		if (i_op == 3'h7)
			refuse = 1'b1;
		else if (i_op == `NSID_OP_RESET)
			refuse = rst_pend_q;
		else if (i_op != `NSID_OP_STATUS)
			refuse = !rb_s_q;
		accept = i_req && (st_q == S_IDLE) && !refuse;
	end

	always @* begin
		eng_kind = `NSID_KIND_CMD;
		eng_byte = cmd1_q;
		case (st_q)
		S_ADDR: begin
			eng_kind = `NSID_KIND_ADDR;
			eng_byte = (aidx_q == 2'h0) ? addr0_q : addr1_q;
		end
		S_CMD2: begin
			eng_byte = `NSID_CMD_COL_CONF;
		end
		S_READ: begin
			eng_kind = `NSID_KIND_READ;
		end
		default: begin
			eng_kind = `NSID_KIND_CMD;
		end
		endcase
		eng_go = eng_idle && !launch_q &&
		         (st_q == S_CMD1 || st_q == S_ADDR || st_q == S_CMD2 || st_q == S_READ);
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q            <= S_IDLE;
			op_q            <= `NSID_OP_STATUS;
			cmd1_q          <= 8'h00;
			addr0_q         <= 8'h00;
			addr1_q         <= 8'h00;
			naddr_q         <= 2'h0;
			aidx_q          <= 2'h0;
			cmd2_q          <= 1'b0;
			wait_q          <= 1'b0;
			nread_q         <= {LEN_W{1'b0}};
			wb_q            <= 4'h0;
			launch_q        <= 1'b0;
			rst_pend_q      <= 1'b0;
			o_busy          <= 1'b0;
			o_done          <= 1'b0;
			o_refused       <= 1'b0;
			o_rd_valid      <= 1'b0;
			o_rd_data       <= 8'h00;
			o_status        <= `NSID_STATUS_RESET;
			o_st_fail       <= 1'b0;
			o_st_fail_prev  <= 1'b0;
			o_st_array_idle <= 1'b1;
			o_st_cache_rdy  <= 1'b1;
			o_st_wp_off     <= 1'b1;
			o_ce_n          <= 1'b1;
			o_wp_n          <= 1'b1;
		end else begin
			o_done     <= 1'b0;
			o_refused  <= i_req && (st_q == S_IDLE) && refuse;
			o_rd_valid <= 1'b0;
			if (eng_go)
				launch_q <= 1'b1;
			else if (eng_done)
				launch_q <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (accept) begin
					st_q    <= S_CMD1;
					op_q    <= i_op;
					o_busy  <= 1'b1;
					o_ce_n  <= 1'b0;
					aidx_q  <= 2'h0;
					addr0_q <= `NSID_ADDR_ID;
					addr1_q <= i_col[15:8];
					naddr_q <= 2'h0;
					cmd2_q  <= 1'b0;
					wait_q  <= 1'b0;
					nread_q <= i_len;
					case (i_op)
					`NSID_OP_STATUS: begin
						cmd1_q  <= `NSID_CMD_STATUS;
						nread_q <= {{(LEN_W-1){1'b0}}, 1'b1};
					end
					`NSID_OP_ID: begin
						cmd1_q  <= `NSID_CMD_READ_ID;
						naddr_q <= 2'h1;
						nread_q <= `NSID_ID_BYTES;
					end
					`NSID_OP_SIG: begin
						cmd1_q  <= `NSID_CMD_READ_ID;
						addr0_q <= `NSID_ADDR_SIG;
						naddr_q <= 2'h1;
						nread_q <= `NSID_SIG_BYTES;
					end
					`NSID_OP_RESET: begin
						cmd1_q     <= `NSID_CMD_RESET;
						wait_q     <= 1'b1;
						nread_q    <= {LEN_W{1'b0}};
						rst_pend_q <= 1'b1;
					end
					`NSID_OP_PARAM: begin
						cmd1_q  <= `NSID_CMD_PARAM;
						naddr_q <= 2'h1;
						wait_q  <= 1'b1;
					end
					`NSID_OP_COL: begin
						cmd1_q  <= `NSID_CMD_COL;
						addr0_q <= i_col[7:0];
						naddr_q <= 2'h2;
						cmd2_q  <= 1'b1;
					end
					default: begin
						cmd1_q <= `NSID_CMD_RESUME;
					end
					endcase
				end
			end
			S_CMD1: begin
				if (eng_done) begin
					if (naddr_q != 2'h0)
						st_q <= S_ADDR;
					else if (wait_q) begin
						st_q <= S_WB;
						wb_q <= cnt_ld(`NSID_WB_CYC - 1);
					end else
						st_q <= (nread_q != {LEN_W{1'b0}}) ? S_READ : S_DONE;
				end
			end
			S_ADDR: begin
				if (eng_done) begin
					aidx_q <= aidx_q + 2'h1;
					if (aidx_q + 2'h1 != naddr_q)
						st_q <= S_ADDR;
					else if (cmd2_q)
						st_q <= S_CMD2;
					else if (wait_q) begin
						st_q <= S_WB;
						wb_q <= cnt_ld(`NSID_WB_CYC - 1);
					end else
						st_q <= (nread_q != {LEN_W{1'b0}}) ? S_READ : S_DONE;
				end
			end
			S_CMD2: begin
				if (eng_done) begin
					st_q <= S_WB;
					wb_q <= cnt_ld(`NSID_WB_CYC - 1);
				end
			end
			// Busy line falls only after tWB, so do not look at it earlier
			S_WB: begin
				if (wb_q == 4'h0)
					st_q <= S_RDY;
				else
					wb_q <= wb_q - 4'h1;
			end
			S_RDY: begin
				if (rb_s_q) begin
					if (op_q == `NSID_OP_RESET)
						rst_pend_q <= 1'b0;
					st_q <= (nread_q != {LEN_W{1'b0}}) ? S_READ : S_DONE;
				end
			end
			S_READ: begin
				if (eng_done) begin
					o_rd_valid <= 1'b1;
					o_rd_data  <= eng_rdata;
					nread_q    <= nread_q - {{(LEN_W-1){1'b0}}, 1'b1};
					if (op_q == `NSID_OP_STATUS) begin
						o_status        <= eng_rdata;
						o_st_fail       <= eng_rdata[`NSID_ST_FAIL];
						o_st_fail_prev  <= eng_rdata[`NSID_ST_FAIL_PREV];
						o_st_array_idle <= eng_rdata[`NSID_ST_ARRAY_IDLE];
						o_st_cache_rdy  <= eng_rdata[`NSID_ST_CACHE_RDY];
						o_st_wp_off     <= eng_rdata[`NSID_ST_WP_OFF];
					end
					if (nread_q == {{(LEN_W-1){1'b0}}, 1'b1})
						st_q <= S_DONE;
				end
			end
			S_DONE: begin
				st_q   <= S_IDLE;
				o_busy <= 1'b0;
				o_done <= 1'b1;
				o_ce_n <= 1'b1;
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule

// File: test/nsid_host_monitor.sv
/* Port assertions for nsid_host.
   Bound from tb; one clock, async active-low reset. */
`timescale 1ns/10ps
module nsid_mon (
	input wire       i_clk_sys,
	input wire       i_rst_b,
	input wire       i_req,
	input wire [2:0] i_op,
	input wire       i_ready_busy_n,
	input wire       o_busy,
	input wire       o_done,
	input wire       o_refused,
	input wire       o_rd_valid,
	input wire [7:0] o_status,
	input wire       o_st_fail,
	input wire       o_st_fail_prev,
	input wire       o_st_array_idle,
	input wire       o_st_cache_rdy,
	input wire       o_st_wp_off,
	input wire       o_ce_n,
	input wire       o_wp_n,
	input wire       o_we_n,
	input wire       o_re_n,
	input wire       o_dq_oe_n
);
	logic [2:0] lo_q;
	// Busy long enough to be past the synchroniser
	always @(posedge i_clk_sys or negedge i_rst_b)
		if (!i_rst_b) lo_q <= 3'h0;
		else if (i_ready_busy_n) lo_q <= 3'h0;
		else if (lo_q != 3'h7) lo_q <= lo_q + 3'h1;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	AST_DONE_PULSE:
		assert property (o_done |=> !o_done) else $error("done too long");
	AST_REF_PULSE:
		assert property (o_refused |=> !o_refused) else $error("refuse too long");
	AST_REF_OP:
		assert property (i_req && !o_busy && i_op == 3'h7 |=> o_refused && !o_busy)
			else $error("bad op taken");
	AST_REF_BUSY:
		assert property (i_req && !o_busy && i_op == 3'h1 && lo_q > 3'h4 |=> o_refused)
			else $error("op taken while busy");
	AST_ST_PASS:
		assert property (o_st_fail == o_status[0] && o_st_fail_prev == o_status[1])
			else $error("pass bits");
	AST_ST_READY:
		assert property (o_st_array_idle == o_status[5] && o_st_cache_rdy == o_status[6])
			else $error("ready bits");
	AST_ST_WP:
		assert property (o_st_wp_off == o_status[7] && o_wp_n) else $error("protect bit");
	AST_WE_DRV:
		assert property (!o_we_n |-> !o_dq_oe_n && !o_ce_n && o_re_n) else $error("write");
	AST_RE_LOW:
		assert property ($fell(o_re_n) |-> (!o_re_n && o_dq_oe_n && !o_ce_n) [*4])
			else $error("read pulse");
	cover property (o_rd_valid);
	cover property (o_refused);
	cover property (o_done && !o_st_array_idle);
endmodule

// File: test/nsid_flash_model.sv
/* Behavioural NAND device: status, ID, signature, reset, parameter page.
   Assumes the bench resolves the shared data bus. */
`timescale 1ns/10ps
module nsid_flash #(
	parameter [39:0] ID_BYTES = 40'h5A3C926126, // Arbitrary codes
	parameter        T_RST_NS = 2000,
	parameter        T_PP_NS  = 500
) (
	input  wire       i_ce_n,
	input  wire       i_cle,
	input  wire       i_ale,
	input  wire       i_we_n,
	input  wire       i_re_n,
	input  wire       i_wp_n,
	input  wire       i_stall,
	input  wire [7:0] i_dq,
	output reg  [7:0] o_dq,
	output wire       o_rb_n
);
	localparam [31:0] SIG = 32'h4F4E4649;
	reg [7:0]  cmd_q, last_q;
	reg [15:0] ptr_q, col_q;
	reg [2:0]  mode_q;
	reg        acnt_q, busy_q, in_rst_q;
	assign o_rb_n = !(busy_q || i_stall);
	// No program or erase here, so both fail bits stay clear
	wire [7:0] stat = {i_wp_n, o_rb_n, o_rb_n, 5'h00};
	function [7:0] pp(input [15:0] p);
		pp = (p < 4) ? SIG[8 * (3 - p) +: 8] : p[7:0] ^ p[15:8] ^ 8'h5A;
	endfunction
	function [7:0] nx(input [15:0] p);
		case (mode_q)
		3'h1: nx = stat;
		3'h2: nx = (p < 5) ? ID_BYTES[8 * (4 - p) +: 8] : ~p[7:0];
		3'h3: nx = (p < 4) ? pp(p) : ~p[7:0];
		3'h4: nx = pp(p);
		default: nx = ~last_q;
		endcase
	endfunction
	initial begin
		{cmd_q, last_q, ptr_q, col_q, mode_q, acnt_q, busy_q, in_rst_q} = 0;
		o_dq = 8'hA5;
	end
	always @(negedge i_re_n)
		if (!i_ce_n) #5 begin
			last_q = nx(ptr_q);
			o_dq = last_q;
		end
	// Released bus inverts so a stale byte never passes
	always @(posedge i_re_n) begin
		if (mode_q != 3'h1) ptr_q = ptr_q + 16'h1;
		#5 o_dq = ~last_q;
	end
	always @(posedge i_we_n)
		if (!i_ce_n && i_cle && !in_rst_q) begin
			cmd_q = i_dq;
			acnt_q = 1'b0;
			if (i_dq == 8'h70) mode_q = 3'h1;
			if (i_dq == 8'h00) mode_q = 3'h4;
			if (i_dq == 8'hE0) begin
				ptr_q = col_q;
				mode_q = 3'h4;
			end
			if (i_dq == 8'hFF) begin
				mode_q = 3'h0;
				in_rst_q = 1'b1;
				#10 busy_q = 1'b1;
				#(T_RST_NS) busy_q = 1'b0;
				in_rst_q = 1'b0;
			end
		end else if (!i_ce_n && i_ale) begin
			if (cmd_q == 8'h90) begin
				mode_q = (i_dq == 8'h20) ? 3'h3 : 3'h2;
				ptr_q = 16'h0000;
			end
			if (cmd_q == 8'h05) col_q = acnt_q ? {i_dq, col_q[7:0]} : {8'h00, i_dq};
			acnt_q = 1'b1;
			if (cmd_q == 8'hEC) begin
				mode_q = 3'h4;
				ptr_q = 16'h0000;
				#10 busy_q = 1'b1;
				#(T_PP_NS) busy_q = 1'b0;
			end
		end
endmodule

// File: test/tb.sv
/* Self-checking bench: nsid_host against nsid_flash, nsid_mon bound.
   User port driven at falling edges. */
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
	localparam [39:0] ID_BYTES = 40'h5A3C926126; // Arbitrary codes
	localparam [31:0] SIG = 32'h4F4E4649;
	logic        i_clk_sys, i_rst_b, i_req, stall, got_done, got_ref;
	logic [2:0]  i_op;
	logic [15:0] i_col;
	logic [8:0]  i_len;
	logic [7:0]  rq[$];
	int          n_fail, total_checks, cyc;
	wire         o_busy, o_done, o_refused, o_rd_valid, o_st_fail, o_st_fail_prev, rb_n;
	wire         o_st_array_idle, o_st_cache_rdy, o_st_wp_off, o_ce_n, o_wp_n;
	wire         o_cle, o_ale, o_we_n, o_re_n, o_dq_oe_n;
	wire [7:0]   o_rd_data, o_status, o_dq_out, dev_dq;
	wire [7:0]   bus_dq = o_dq_oe_n ? dev_dq : o_dq_out;
	nsid_host dut_u (.i_clk_sys, .i_rst_b, .i_req, .i_op, .i_col, .i_len,
		.i_ready_busy_n(rb_n), .i_dq_in(bus_dq), .o_busy, .o_done, .o_refused, .o_rd_valid,
		.o_rd_data, .o_status, .o_st_fail, .o_st_fail_prev, .o_st_array_idle,
		.o_st_cache_rdy, .o_st_wp_off, .o_ce_n, .o_wp_n, .o_cle, .o_ale, .o_we_n,
		.o_re_n, .o_dq_out, .o_dq_oe_n);
	nsid_flash #(.ID_BYTES(ID_BYTES)) dev_u (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
		.i_we_n(o_we_n), .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_stall(stall), .i_dq(bus_dq),
		.o_dq(dev_dq), .o_rb_n(rb_n));
	function [7:0] pp(input [15:0] p);
		pp = (p < 4) ? SIG[8 * (3 - p) +: 8] : p[7:0] ^ p[15:8] ^ 8'h5A;
	endfunction
	always @(posedge i_clk_sys) begin
		if (o_rd_valid) rq.push_back(o_rd_data);
		got_done |= o_done;
		got_ref |= o_refused;
	end
	task automatic run(input [2:0] op, input [15:0] col, input [8:0] len, input bit refd);
		int n;
		n = 0;
		while (o_busy) @(negedge i_clk_sys);
		rq = {};
		{got_done, got_ref} = 2'h0;
		i_req = 1'b1;
		{i_op, i_col, i_len} = {op, col, len};
		@(negedge i_clk_sys);
		i_req = 1'b0;
		while (!got_done && !got_ref && n < 4000) begin
			@(negedge i_clk_sys);
			n++;
		end
		cyc = n;
		`CHK({got_done, got_ref}, {!refd, refd})
	endtask
	task automatic chk_pp(input [15:0] s, input int k);
		`CHK(rq.size(), k)
		for (int i = 0; i < k; i++) `CHK(rq[i], pp(s + 16'(i)))
	endtask
	task close_out;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	// Whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_fail++;
		close_out;
	end
	initial begin
		{i_rst_b, i_req, stall, i_op, i_col, i_len, got_done, got_ref} = 0;
		repeat (6) @(negedge i_clk_sys);
		i_rst_b = 1'b1;
		`CHK(o_status, 8'hE0)
		`CHK({o_st_wp_off, o_st_cache_rdy, o_st_array_idle, o_st_fail_prev, o_st_fail}, 5'h1C)
		repeat (3) @(negedge i_clk_sys);
		run(0, 0, 0, 0);
		`CHK(rq[0], 8'hE0)
		run(1, 0, 0, 0);
		`CHK(rq.size(), 5)
		for (int i = 0; i < 5; i++) `CHK(rq[i], ID_BYTES[8 * (4 - i) +: 8])
		run(2, 0, 0, 0);
		chk_pp(0, 4);
		run(4, 0, 6, 0);
		chk_pp(0, 6);
		run(0, 0, 0, 0);
		`CHK(o_status, 8'hE0)
		run(6, 0, 3, 0);
		chk_pp(6, 3);
		run(5, 16'h0150, 3, 0);
		chk_pp(16'h0150, 3);
		run(4, 0, 2, 0);
		chk_pp(0, 2);
		run(3, 0, 0, 0);
		`CHK(cyc >= 80, 1'b1)
		run(0, 0, 0, 0);
		`CHK(rq[0], 8'hE0)
		stall = 1'b1;
		repeat (6) @(negedge i_clk_sys);
		run(1, 0, 0, 1);
		run(0, 0, 0, 0);
		`CHK(rq[0], 8'h80)
		`CHK(o_st_array_idle, 1'b0)
		`CHK(o_st_cache_rdy, 1'b0)
		// Reset is taken while the device is busy and must outlast the stall
		fork
			begin
				repeat (20) @(negedge i_clk_sys);
				stall = 1'b0;
			end
		join_none
		run(3, 0, 0, 0);
		`CHK(cyc >= 80, 1'b1)
		repeat (4) @(negedge i_clk_sys);
		run(7, 0, 0, 1);
		close_out;
	end
endmodule
bind nsid_host nsid_mon mon_u (.i_clk_sys, .i_rst_b, .i_req, .i_op, .i_ready_busy_n, .o_busy,
	.o_done, .o_refused, .o_rd_valid, .o_status, .o_st_fail, .o_st_fail_prev, .o_st_array_idle,
	.o_st_cache_rdy, .o_st_wp_off, .o_ce_n, .o_wp_n, .o_we_n, .o_re_n, .o_dq_oe_n);
